// [verilog/tcc_pkg.sv]
package tcc_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] ADDR_MODE     = 8'h00;
    localparam logic [7:0] ADDR_CCCTRL   = 8'h04;
    localparam logic [7:0] ADDR_PRESCALE = 8'h08;
    localparam logic [7:0] ADDR_OUTCTRL  = 8'h0C;
    localparam logic [7:0] ADDR_COUNT    = 8'h10;
    localparam logic [7:0] ADDR_CC_A     = 8'h14;
    localparam logic [7:0] ADDR_CC_B     = 8'h18;
    localparam logic [7:0] ADDR_STATUS   = 8'h1C;
    localparam logic [7:0] ADDR_MASK     = 8'h20;

    // Mode register fields
    localparam int MODE_OP_LO = 2;
    localparam int MODE_OP_HI = 3;

    // Capture/compare control fields
    localparam int CC_A_CAPTURE = 0;  // 1: register a captures, 0: compare
    localparam int CC_A_REVERSE = 1;  // 1: a captures on reverse phase of pin a
    localparam int CC_B_CAPTURE = 2;  // 1: register b captures, 0: compare

    // Prescaler fields
    localparam int PRE_SEL_LO = 0;
    localparam int PRE_SEL_HI = 1;
    localparam int PRE_EDGE_A = 4;    // Valid edge select for pin a: 0 rise, 1 fall
    localparam int PRE_EDGE_B = 5;    // Valid edge select for pin b: 0 rise, 1 fall
    localparam logic [1:0] PRE_EXT_EDGE = 2'b11;

    // Output control fields
    localparam int OUT_MODE_LO  = 1;
    localparam int OUT_FORCE_LO = 2;
    localparam int OUT_FORCE_HI = 3;
    localparam int OUT_MODE_HI  = 4;
    localparam int OUT_ENABLE   = 0;

    // Status and mask bits
    localparam int ST_CAPCMP_A = 0;
    localparam int ST_CAPCMP_B = 1;
    localparam int ST_ORDER_ERR = 2;

    // Prescale dividers, as log2 of the division
    localparam int DIV_SHIFT_0 = 0;
    localparam int DIV_SHIFT_1 = 2;
    localparam int DIV_SHIFT_2 = 8;

    // Reset values
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] RST_CC    = 16'h0000;
    localparam logic [7:0]  RST_CTRL  = 8'h00;
    localparam logic [7:0]  RST_CCCTRL = 8'h05;

endpackage

// [verilog/tcc_pin_edge.sv]
`timescale 1ns/10ps
// Pin synchroniser and edge detector; edges are qualified by the run input
module tcc_pin_edge
    import tcc_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    input  wire logic run,
    input  wire logic sel_fall,
    output logic      level,
    output logic      edge_seen
);
    logic meta;
    logic sync;
    logic last;

    // Two flops before any logic reads the pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
        end
        else
        begin
            meta <= pin;
            sync <= meta;
        end
    end

    // Last level is reloaded while stopped, so restarting does not see a stale edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last <= 1'b0;
        else
            last <= sync;
    end

    assign level     = sync;
    assign edge_seen = run && (sel_fall ? (last && !sync) : (!last && sync));
endmodule

// [verilog/tcc_top.sv]
`timescale 1ns/10ps
// Function
// - Reading the count register never captures into register b.
// - Register a in compare mode ignores capture triggers and keeps its value.
// - Register b in compare mode ignores capture triggers and keeps its value.
// - A reverse-phase capture of pin a into register a raises no a-interrupt.
// - In reverse-phase mode a pin b edge captures nothing but still raises the a-interrupt, unless prescale select is 11.
// - The counter runs while the two mode bits are not 00 and stops at 00.
// - Prescale select 11 makes valid edges on pin a the count clock.
// - A captured value in register a stays until the next capture or, in compare mode, an APB write to it.
module tcc_top
    import tcc_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             trigger_pin_a,
    input  wire logic             trigger_pin_b,
    output logic                  capcmp_a_irq,
    output logic                  irq
);
    // Elaboration refuses widths that the fixed 16-bit registers cannot serve
    if (CNT_W != 16)
    begin
        $error("tcc_top supports only a 16 bit counter");
    end

    logic [7:0]  timer_mode_ctrl;
    logic [7:0]  capcmp_ctrl;
    logic [7:0]  prescale_mode;
    logic [7:0]  output_ctrl;
    logic [15:0] count_value_reg;
    logic [15:0] capcmp_reg_a;
    logic [15:0] capcmp_reg_b;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic [7:0]  div_cnt;
    logic        order_step;
    logic        level_a;
    logic        level_b;
    logic        edge_a;
    logic        edge_b;
    logic        edge_a_rev;
    logic        running;
    logic        tick;
    logic        wr_en;
    logic        rd_en;
    logic [1:0]  pre_sel;
    logic        cap_a;
    logic        cap_b;
    logic        ext_a_irq;
    logic [2:0]  events;
    logic [31:0] next_prdata;

    // Address decode helper, used for every register write
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        return addr == reg_addr;
    endfunction

    // The slave always answers in the access cycle, no wait states
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pslverr = psel && penable && !(hit(paddr, ADDR_MODE) || hit(paddr, ADDR_CCCTRL)
                     || hit(paddr, ADDR_PRESCALE) || hit(paddr, ADDR_OUTCTRL)
                     || hit(paddr, ADDR_COUNT) || hit(paddr, ADDR_CC_A)
                     || hit(paddr, ADDR_CC_B) || hit(paddr, ADDR_STATUS)
                     || hit(paddr, ADDR_MASK));

    // Counter runs whenever the two mode bits are not 00
    assign running = timer_mode_ctrl[MODE_OP_HI] || timer_mode_ctrl[MODE_OP_LO];
    assign pre_sel = {prescale_mode[PRE_SEL_HI], prescale_mode[PRE_SEL_LO]};

    tcc_pin_edge u_pin_a
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin       (trigger_pin_a),
        .run       (running),
        .sel_fall  (prescale_mode[PRE_EDGE_A]),
        .level     (level_a),
        .edge_seen (edge_a)
    );

    tcc_pin_edge u_pin_b
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin       (trigger_pin_b),
        .run       (running),
        .sel_fall  (prescale_mode[PRE_EDGE_B]),
        .level     (level_b),
        .edge_seen (edge_b)
    );

    tcc_pin_edge u_pin_a_rev
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin       (trigger_pin_a),
        .run       (running),
        .sel_fall  (!prescale_mode[PRE_EDGE_A]),
        .level     (),
        .edge_seen (edge_a_rev)
    );

    // Count tick: divided pclk, or pin a edges when select is 11
    always_comb
    begin
        unique case (pre_sel)
            2'b00:   tick = running;
            2'b01:   tick = running && (div_cnt[DIV_SHIFT_1-1:0] == '1);
            2'b10:   tick = running && (div_cnt[DIV_SHIFT_2-1:0] == '1);
            default: tick = edge_a;
        endcase
    end

    // Free divider, held in reset while stopped so timing restarts cleanly
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_cnt <= 8'h00;
        else if (!running)
            div_cnt <= 8'h00;
        else
            div_cnt <= div_cnt + 8'h01;
    end

    // Count register; writable only while stopped to avoid mid-count tears
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_value_reg <= RST_COUNT;
        else if (wr_en && hit(paddr, ADDR_COUNT) && !running)
            count_value_reg <= pwdata[15:0];
        else if (tick)
            count_value_reg <= count_value_reg + 16'h0001;
    end

    // Capture decisions; pin a as count clock cannot also capture
    always_comb
    begin
        cap_a     = 1'b0;
        ext_a_irq = 1'b0;
        if (capcmp_ctrl[CC_A_CAPTURE] && pre_sel != PRE_EXT_EDGE)
        begin
            if (capcmp_ctrl[CC_A_REVERSE])
            begin
                cap_a     = edge_a_rev;
                ext_a_irq = edge_b;
            end
            else
            begin
                cap_a = edge_b;
            end
        end
        cap_b = capcmp_ctrl[CC_B_CAPTURE] && edge_a && pre_sel != PRE_EXT_EDGE;
    end

    // Register a: capture copies the live count in the detect cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            capcmp_reg_a <= RST_CC;
        else if (cap_a)
            capcmp_reg_a <= count_value_reg;
        else if (wr_en && hit(paddr, ADDR_CC_A) && !capcmp_ctrl[CC_A_CAPTURE])
            capcmp_reg_a <= pwdata[15:0];
    end

    // Register b: reads of the count never reach here, only real triggers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            capcmp_reg_b <= RST_CC;
        else if (cap_b)
            capcmp_reg_b <= count_value_reg;
        else if (wr_en && hit(paddr, ADDR_CC_B) && !capcmp_ctrl[CC_B_CAPTURE])
            capcmp_reg_b <= pwdata[15:0];
    end

    // Compare match or capture events
    assign events[ST_CAPCMP_A] = ext_a_irq || (cap_a && !capcmp_ctrl[CC_A_REVERSE])
                                 || (tick && !capcmp_ctrl[CC_A_CAPTURE]
                                     && count_value_reg == capcmp_reg_a);
    assign events[ST_CAPCMP_B] = cap_b || (tick && !capcmp_ctrl[CC_B_CAPTURE]
                                           && count_value_reg == capcmp_reg_b);
    assign events[ST_ORDER_ERR] = 1'b0;

    // Control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_mode_ctrl <= RST_CTRL;
            capcmp_ctrl     <= RST_CCCTRL;
            prescale_mode   <= RST_CTRL;
            mask            <= 3'b000;
        end
        else if (wr_en)
        begin
            if (hit(paddr, ADDR_MODE))
                timer_mode_ctrl <= pwdata[7:0];
            if (hit(paddr, ADDR_CCCTRL))
                capcmp_ctrl <= pwdata[7:0];
            if (hit(paddr, ADDR_PRESCALE))
                prescale_mode <= pwdata[7:0];
            if (hit(paddr, ADDR_MASK))
                mask <= pwdata[2:0];
        end
    end

    // Output control; out-of-order writes flag a status bit since software owns the order
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            output_ctrl <= RST_CTRL;
            order_step  <= 1'b0;
        end
        else if (wr_en && hit(paddr, ADDR_OUTCTRL))
        begin
            output_ctrl <= pwdata[7:0];
            order_step  <= pwdata[OUT_MODE_HI] && pwdata[OUT_MODE_LO];
        end
    end

    // Sticky status; a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status <= 3'b000;
        else
        begin
            status[ST_CAPCMP_A] <= events[ST_CAPCMP_A]
                || (status[ST_CAPCMP_A] && !(wr_en && hit(paddr, ADDR_STATUS)
                                             && pwdata[ST_CAPCMP_A]));
            status[ST_CAPCMP_B] <= events[ST_CAPCMP_B]
                || (status[ST_CAPCMP_B] && !(wr_en && hit(paddr, ADDR_STATUS)
                                             && pwdata[ST_CAPCMP_B]));
            status[ST_ORDER_ERR] <= (wr_en && hit(paddr, ADDR_OUTCTRL)
                                     && (pwdata[OUT_FORCE_LO] || pwdata[OUT_FORCE_HI])
                                     && !(order_step && output_ctrl[OUT_ENABLE]))
                || (status[ST_ORDER_ERR] && !(wr_en && hit(paddr, ADDR_STATUS)
                                              && pwdata[ST_ORDER_ERR]));
        end
    end

    // Read mux, registered data, zero for unmapped
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (hit(paddr, ADDR_MODE))
            next_prdata = {24'h00_0000, timer_mode_ctrl};
        else if (hit(paddr, ADDR_CCCTRL))
            next_prdata = {24'h00_0000, capcmp_ctrl};
        else if (hit(paddr, ADDR_PRESCALE))
            next_prdata = {24'h00_0000, prescale_mode};
        else if (hit(paddr, ADDR_OUTCTRL))
            next_prdata = {24'h00_0000, output_ctrl};
        else if (hit(paddr, ADDR_COUNT))
            next_prdata = {16'h0000, count_value_reg};
        else if (hit(paddr, ADDR_CC_A))
            next_prdata = {16'h0000, capcmp_reg_a};
        else if (hit(paddr, ADDR_CC_B))
            next_prdata = {16'h0000, capcmp_reg_b};
        else if (hit(paddr, ADDR_STATUS))
            next_prdata = {29'h0000_0000, status};
        else if (hit(paddr, ADDR_MASK))
            next_prdata = {29'h0000_0000, mask};
    end

    // Read data registered at setup so it is stable through the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= next_prdata;
    end

    // Interrupt outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            capcmp_a_irq <= 1'b0;
            irq          <= 1'b0;
        end
        else
        begin
            capcmp_a_irq <= events[ST_CAPCMP_A];
            irq          <= |(status & mask);
        end
    end

    logic unused_ok;
    assign unused_ok = rd_en ^ level_a ^ level_b;
endmodule

// [dv/tcc_props.sv]
`timescale 1ns/10ps
// Watches the bus and pins of the timer block
module tcc_props
    import tcc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        trigger_pin_a,
    input wire logic        trigger_pin_b,
    input wire logic        capcmp_a_irq,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic        acc, rd, wr, run, rev, norm, pre0, pa_q, pb_q, stale_b, stale_c;
    logic [3:0]  age_a, age_b;
    logic [31:0] last_b, last_c;
    assign acc = psel && penable && pready;
    assign rd  = acc && !pwrite;
    assign wr  = acc && pwrite;
    // Mirror of the mode fields as last written
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {run, rev, norm, pre0} <= 4'b0011;
        else if (wr && paddr == ADDR_MODE)
            run <= |pwdata[3:2];
        else if (wr && paddr == ADDR_CCCTRL)
            {rev, norm} <= {pwdata[1:0] == 2'b11, pwdata[1:0] == 2'b01};
        else if (wr && paddr == ADDR_PRESCALE)
            pre0 <= pwdata[1:0] == 2'b00;
    // Cycles since a pin moved; eight covers sync plus capture delay
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {pa_q, pb_q, age_a, age_b} <= '0;
        else
        begin
            {pa_q, pb_q} <= {trigger_pin_a, trigger_pin_b};
            age_a <= (trigger_pin_a != pa_q) ? 4'h0 : age_a + {3'h0, age_a != 4'hf};
            age_b <= (trigger_pin_b != pb_q) ? 4'h0 : age_b + {3'h0, age_b != 4'hf};
        end
    // Last reads of count and register b; any possible change makes them stale
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {stale_b, stale_c, last_b, last_c} <= {2'b11, 64'h0};
        else
        begin
            if (rd && paddr == ADDR_CC_B)
                {stale_b, last_b} <= {1'b0, prdata};
            if (rd && paddr == ADDR_COUNT)
                {stale_c, last_c} <= {1'b0, prdata};
            if (age_a < 4'h8 || (wr && paddr == ADDR_CC_B))
                stale_b <= 1'b1;
            if (run || (wr && (paddr == ADDR_COUNT || paddr == ADDR_MODE)))
                stale_c <= 1'b1;
        end
    property p_unmapped;
        acc && paddr > ADDR_MASK |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
    property p_mapped;
        acc && paddr <= ADDR_MASK && paddr[1:0] == 2'b00 |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_pulse;
        capcmp_a_irq |=> !capcmp_a_irq;
    endproperty
    a_pulse: assert property (p_pulse) else $error("a-interrupt longer than a cycle");
    property p_b_hold;
        rd && paddr == ADDR_CC_B && !stale_b |-> prdata == last_b;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("register b moved");
    property p_stop;
        rd && paddr == ADDR_COUNT && !stale_c && !run |-> prdata == last_c;
    endproperty
    a_stop: assert property (p_stop) else $error("stopped count moved");
    property p_rev_quiet;
        capcmp_a_irq && rev |-> age_b < 4'h8;
    endproperty
    a_rev_quiet: assert property (p_rev_quiet) else $error("reverse irq");
    property p_rev_ext;
        rev && run && pre0 && $rose(trigger_pin_b) |-> ##[2:6] capcmp_a_irq;
    endproperty
    a_rev_ext: assert property (p_rev_ext) else $error("no external irq");
    property p_norm;
        norm && run && pre0 && $rose(trigger_pin_b) |-> ##[2:6] capcmp_a_irq;
    endproperty
    a_norm: assert property (p_norm) else $error("capture irq missing");
    c_rev: cover property (rev && capcmp_a_irq);
    c_hold: cover property (rd && paddr == ADDR_CC_B && !stale_b);
    c_err: cover property (acc && pslverr);
endmodule

bind tcc_top tcc_props u_tcc_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_pin_a(trigger_pin_a),
    .trigger_pin_b(trigger_pin_b), .capcmp_a_irq(capcmp_a_irq), .irq(irq)
);

// [dv/tcc_pin_src.sv]
`timescale 1ns/10ps
// Stand-in for the external pulse sources on the two trigger pins
module tcc_pin_src
(
    input  wire logic pclk,
    output logic      pin_a,
    output logic      pin_b
);
    // Idle low, so enabling the timer never sees a false rising edge
    initial {pin_a, pin_b} = 2'b00;
    // High for hi cycles then low for lo; callers keep hi at three or more
    task automatic pulse(input logic sel_b, input int hi, input int lo);
        @(posedge pclk);
        {pin_a, pin_b} <= {!sel_b, sel_b};
        repeat (hi) @(posedge pclk);
        {pin_a, pin_b} <= 2'b00;
        repeat (lo) @(posedge pclk);
    endtask
endmodule

// [dv/tb_top.sv]
`timescale 1ns/10ps
module tb_top
    import tcc_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv, v, x;
    logic        pready, pslverr, err, pin_a, pin_b, capcmp_a_irq, irq;
    logic [63:0] exp_q[$], e;
    logic [31:0] seed = 32'h0000_dcbe;
    int          errors = 0, compares = 0, irqs = 0, n0;

    tcc_top u_tcc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trigger_pin_a(pin_a), .trigger_pin_b(pin_b),
        .capcmp_a_irq(capcmp_a_irq), .irq(irq));
    tcc_pin_src u_tcc_pin_src (.pclk(pclk), .pin_a(pin_a), .pin_b(pin_b));

    always #4 pclk = ~pclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want)
        begin
            errors++;
            $display("unexpected at %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic results;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic [31:0] rnd;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // One APB transfer; a read leaves a note of its expected data
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [31:0] m);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        if (!w)
            exp_q.push_back({m, d & m});
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        {rv, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1)
        begin
            errors++;
            results();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        xfer(1'b0, a, d, m);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0);
    endtask

    // Random widths, never under three count clocks at the pclk rate
    task automatic pls(input logic sel_b);
        u_tcc_pin_src.pulse(sel_b, 3 + int'(rnd() % 6), 8 + int'(rnd() % 8));
    endtask

    // Oldest note is compared with each completed read
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            e = exp_q.pop_front();
            check(prdata & e[63:32], e[31:0]);
        end

    // Pulses on the a-interrupt, counted by the bench
    always @(posedge pclk)
        if (capcmp_a_irq === 1'b1)
            irqs++;

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values over the map, then a hole past the last register
        for (int i = 0; i < 9; i++)
            rd(8'(4 * i), (i == 1) ? {24'h0, RST_CCCTRL} : 32'h0, 32'hffff_ffff);
        rd(ADDR_MASK + 8'h4, 32'h0, 32'hffff_ffff);
        check({31'h0, err}, 32'h1);
        // Internal clock; many count reads must leave register b untouched
        wr(ADDR_MASK, 32'h3);
        wr(ADDR_MODE, 32'hc);
        rd(ADDR_COUNT, 32'h0, 32'h0);
        v = rv;
        repeat (4) rd(ADDR_COUNT, 32'h0, 32'h0);
        check({31'h0, rv != v}, 32'h1);
        rd(ADDR_CC_B, 32'h0, 32'hffff_ffff);
        // Pin a captures into b; status, level interrupt, clear, then masked
        pls(1'b0);
        rd(ADDR_CC_B, 32'h0, 32'h0);
        check({31'h0, rv > v && rv - v < 32'd100}, 32'h1);
        rd(ADDR_STATUS, 32'h2, 32'h2);
        check({31'h0, irq}, 32'h1);
        wr(ADDR_STATUS, 32'h2);
        rd(ADDR_STATUS, 32'h0, 32'h2);
        check({31'h0, irq}, 32'h0);
        wr(ADDR_MASK, 32'h1);
        pls(1'b0);
        rd(ADDR_STATUS, 32'h2, 32'h2);
        check({31'h0, irq}, 32'h0);
        wr(ADDR_STATUS, 32'h2);
        // Pin b captures into a and pulses the a-interrupt once
        n0 = irqs;
        pls(1'b1);
        rd(ADDR_CC_A, 32'h0, 32'h0);
        x = rv;
        check({31'h0, x != 32'h0}, 32'h1);
        check(32'(irqs), 32'(n0 + 1));
        check({31'h0, irq}, 32'h1);
        wr(ADDR_STATUS, 32'h1);
        // Compare mode: triggers ignored, a keeps its capture, b its value
        wr(ADDR_MODE, 32'h0);
        wr(ADDR_CCCTRL, 32'h0);
        v = rnd();
        wr(ADDR_CC_B, {16'h0, v[15:0]});
        wr(ADDR_MODE, 32'h4);
        pls(1'b0);
        pls(1'b1);
        rd(ADDR_CC_A, x, 32'hffff_ffff);
        rd(ADDR_CC_B, {16'h0, v[15:0]}, 32'hffff_ffff);
        // Reverse phase: pin a fall captures quietly, pin b only interrupts
        wr(ADDR_MODE, 32'h0);
        wr(ADDR_CCCTRL, 32'h3);
        wr(ADDR_MODE, 32'hc);
        n0 = irqs;
        pls(1'b0);
        rd(ADDR_CC_A, 32'h0, 32'h0);
        check({31'h0, rv != x}, 32'h1);
        check(32'(irqs), 32'(n0));
        x = rv;
        pls(1'b1);
        rd(ADDR_CC_A, x, 32'hffff_ffff);
        check(32'(irqs), 32'(n0 + 1));
        // Pin a edges as count clock, then a stop freezes the count
        wr(ADDR_MODE, 32'h0);
        wr(ADDR_CCCTRL, 32'h1);
        wr(ADDR_PRESCALE, {30'h0, PRE_EXT_EDGE});
        wr(ADDR_MODE, 32'hc);
        rd(ADDR_COUNT, 32'h0, 32'h0);
        v = rv;
        repeat (4) pls(1'b0);
        rd(ADDR_COUNT, v + 32'h4, 32'hffff);
        wr(ADDR_MODE, 32'h0);
        rd(ADDR_COUNT, 32'h0, 32'h0);
        v = rv;
        pls(1'b0);
        rd(ADDR_COUNT, v, 32'hffff_ffff);
        // Divide by four: count samples twelve cycles apart must differ by three
        wr(ADDR_PRESCALE, 32'h1);
        wr(ADDR_MODE, 32'hc);
        rd(ADDR_COUNT, 32'h0, 32'h0);
        v = rv;
        repeat (3) rd(ADDR_STATUS, 32'h0, 32'h0);
        rd(ADDR_COUNT, v + 32'h3, 32'hffff);
        // Output control set up as mode, then enable, then a force bit
        wr(ADDR_OUTCTRL, 32'h12);
        wr(ADDR_OUTCTRL, 32'h13);
        wr(ADDR_OUTCTRL, 32'h17);
        rd(ADDR_STATUS, 32'h0, 32'h4);
        rd(ADDR_OUTCTRL, 32'h17, 32'h1f);
        results();
    end
endmodule
